// file: src/dpram_core.sv
// True dual-port 4096-cell RAM with collision modelling
//
// Behaviour
// - Same-cell double write leaves cell invalid
// - Write-read clash: writer mirrors, reader invalid
// - Only shared cells with a write interact
// - All port inputs sampled on clock edge
// - Enable without write reads addressed word
// - Write stores word and mirrors it out
// - Disabled port holds its last output
// - Each port starts disabled
// - Other port's write leaves a disabled port's output alone
// - Read after settled write returns new word
// - Double write still mirrors each input
// - Sixteen 256-bit start-up values fill array
// - Missing start-up value gives zeros
// - Short start-up value padded with zeros
// - Output reset clears output word only
// - Word width sets depth, start address times width
// - Enable, write, reset polarity options
`timescale 1ns/10ps
module dpram_core
#(
   parameter int unsigned WIDTH_A = 16,
   parameter int unsigned WIDTH_B = 16,
   parameter bit INV_EN_A = 1'b0,
   parameter bit INV_WE_A = 1'b0,
   parameter bit INV_RST_A = 1'b0,
   parameter bit INV_EN_B = 1'b0,
   parameter bit INV_WE_B = 1'b0,
   parameter bit INV_RST_B = 1'b0,
   parameter int unsigned WINDOW_CYCLES = 0,
   parameter dpram_pkg::dpram_init_t INIT = '0
)
(
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   // Port A
   input wire logic PORT_A_ENABLE,
   input wire logic PORT_A_WRITE,
   input wire logic PORT_A_OUT_RESET,
   input wire dpram_pkg::dpram_addr_t PORT_A_ADDR,
   input wire dpram_pkg::dpram_word_t PORT_A_WORD_IN,
   output dpram_pkg::dpram_word_t PORT_A_WORD_OUT,
   output logic PORT_A_ACTIVE,
   // Port B
   input wire logic PORT_B_ENABLE,
   input wire logic PORT_B_WRITE,
   input wire logic PORT_B_OUT_RESET,
   input wire dpram_pkg::dpram_addr_t PORT_B_ADDR,
   input wire dpram_pkg::dpram_word_t PORT_B_WORD_IN,
   output dpram_pkg::dpram_word_t PORT_B_WORD_OUT,
   output logic PORT_B_ACTIVE
);
   import dpram_pkg::*;

   // Extract a word from the array
   function automatic dpram_word_t read_word(input logic [DPRAM_MEM_BITS-1:0] m,
                                             input dpram_addr_t lo, input int unsigned w);
      dpram_word_t r;
      r = DPRAM_WORD_ZERO;
      for (int i = 0; i < DPRAM_DATA_W; i++)
         if (i < w)
            r[i] = m[DPRAM_ADDR_W'(32'(lo) + i)];
      return r;
   endfunction

   // Keep only the bits a port of this width carries
   function automatic dpram_word_t mask_word(input dpram_word_t d, input int unsigned w);
      dpram_word_t r;
      r = DPRAM_WORD_ZERO;
      for (int i = 0; i < DPRAM_DATA_W; i++)
         if (i < w)
            r[i] = d[i];
      return r;
   endfunction

   dpram_req_t ra, rb; // Sampled requests
   dpram_addr_t a_lo, a_hi, b_lo, b_hi; // Cell ranges
   dpram_last_t la, lb; // Last accesses
   logic a_act, b_act; // Port state flags
   logic [DPRAM_MEM_BITS-1:0] mem, next_mem; // Cell array
   dpram_word_t next_out_a, next_out_b; // Next output words
   logic a_wr, b_wr, ov_now, ww, a_rd_bad, b_rd_bad, a_wr_bad, b_wr_bad;

   // Front ends
   dpram_port #(.WIDTH(WIDTH_A), .INV_EN(INV_EN_A), .INV_WE(INV_WE_A), .INV_RST(INV_RST_A))
   u_port_a (.clk_sys(CLK_SYS), .reset_n(RESET_N), .en_pin(PORT_A_ENABLE),
      .we_pin(PORT_A_WRITE), .rst_pin(PORT_A_OUT_RESET), .addr(PORT_A_ADDR),
      .din(PORT_A_WORD_IN), .req(ra), .lo(a_lo), .hi(a_hi), .last(la), .active(a_act));
   dpram_port #(.WIDTH(WIDTH_B), .INV_EN(INV_EN_B), .INV_WE(INV_WE_B), .INV_RST(INV_RST_B))
   u_port_b (.clk_sys(CLK_SYS), .reset_n(RESET_N), .en_pin(PORT_B_ENABLE),
      .we_pin(PORT_B_WRITE), .rst_pin(PORT_B_OUT_RESET), .addr(PORT_B_ADDR),
      .din(PORT_B_WORD_IN), .req(rb), .lo(b_lo), .hi(b_hi), .last(lb), .active(b_act));

   // Collision detection
   always_comb
   begin
      a_wr = ra.en && ra.we;
      b_wr = rb.en && rb.we;
      ov_now = ra.en && rb.en && dpram_overlap(a_lo, a_hi, b_lo, b_hi);
      ww = ov_now && a_wr && b_wr;
      // other port's write still inside window
      a_wr_bad = ra.en && lb.valid && lb.we && (32'(lb.age) < WINDOW_CYCLES) &&
                 dpram_overlap(a_lo, a_hi, lb.lo, lb.hi);
      b_wr_bad = rb.en && la.valid && la.we && (32'(la.age) < WINDOW_CYCLES) &&
                 dpram_overlap(b_lo, b_hi, la.lo, la.hi);
      // reader of a clashing write is invalid
      a_rd_bad = ra.en && !ra.we && ((ov_now && b_wr) || a_wr_bad);
      b_rd_bad = rb.en && !rb.we && ((ov_now && a_wr) || b_wr_bad);
   end

   // Array next value
   always_comb
   begin
      next_mem = mem;
      for (int i = 0; i < DPRAM_DATA_W; i++)
      begin
         if (a_wr && i < WIDTH_A)
            next_mem[DPRAM_ADDR_W'(32'(a_lo) + i)] = ra.din[i];
         if (b_wr && i < WIDTH_B)
            next_mem[DPRAM_ADDR_W'(32'(b_lo) + i)] = rb.din[i];
      end
      for (int i = 0; i < DPRAM_DATA_W; i++)
      begin
         if (i < WIDTH_A && (ww || (a_wr && a_wr_bad)) &&
             dpram_overlap(DPRAM_ADDR_W'(32'(a_lo) + i), DPRAM_ADDR_W'(32'(a_lo) + i),
                           ww ? b_lo : lb.lo, ww ? b_hi : lb.hi))
            next_mem[DPRAM_ADDR_W'(32'(a_lo) + i)] = 1'bx;
         if (i < WIDTH_B && b_wr && b_wr_bad &&
             dpram_overlap(DPRAM_ADDR_W'(32'(b_lo) + i), DPRAM_ADDR_W'(32'(b_lo) + i),
                           la.lo, la.hi))
            next_mem[DPRAM_ADDR_W'(32'(b_lo) + i)] = 1'bx;
      end
   end

   // Output words next value
   always_comb
   begin
      next_out_a = PORT_A_WORD_OUT;
      next_out_b = PORT_B_WORD_OUT;
      if (ra.en)
      begin
         if (ra.rst)
            next_out_a = DPRAM_WORD_ZERO;
         else if (a_wr)
            next_out_a = mask_word(ra.din, WIDTH_A);
         else if (a_rd_bad)
            next_out_a = 'x;
         else
            next_out_a = read_word(mem, a_lo, WIDTH_A);
      end
      // port B output changes only when port B is enabled
      if (rb.en)
      begin
         if (rb.rst)
            next_out_b = DPRAM_WORD_ZERO;
         else if (b_wr)
            next_out_b = mask_word(rb.din, WIDTH_B);
         else if (b_rd_bad)
            next_out_b = 'x;
         else
            next_out_b = read_word(mem, b_lo, WIDTH_B);
      end
   end

   // Registers: array starts from configured contents
   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         mem <= INIT;
         PORT_A_WORD_OUT <= DPRAM_WORD_ZERO;
         PORT_B_WORD_OUT <= DPRAM_WORD_ZERO;
      end
      else
      begin
         // everything taken on the same edge
         mem <= next_mem;
         PORT_A_WORD_OUT <= next_out_a;
         PORT_B_WORD_OUT <= next_out_b;
      end
   end

   assign PORT_A_ACTIVE = a_act;
   assign PORT_B_ACTIVE = b_act;

   // Checks
   idle_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      !ra.en |=> $stable(PORT_A_WORD_OUT)) else $error("idle port A output moved");
   other_write_iso_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (b_wr && !ra.en) |=> $stable(PORT_A_WORD_OUT))
      else $error("port B write changed port A output");
   write_mirror_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (a_wr && !ra.rst) |=> PORT_A_WORD_OUT == mask_word($past(ra.din), WIDTH_A))
      else $error("port A write not mirrored");
   read_word_b_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (rb.en && !rb.we && !rb.rst && !b_rd_bad)
      |=> PORT_B_WORD_OUT === read_word($past(mem), $past(b_lo), WIDTH_B))
      else $error("port B read wrong word");
   out_reset_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (ra.en && ra.rst) |=> PORT_A_WORD_OUT == DPRAM_WORD_ZERO
      && ($past(ra.we) || $past(b_wr) || mem === $past(mem)))
      else $error("port A output reset failed");
   dual_write_out_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (ww && !ra.rst && !rb.rst) |=> PORT_A_WORD_OUT == mask_word($past(ra.din), WIDTH_A)
      && PORT_B_WORD_OUT == mask_word($past(rb.din), WIDTH_B))
      else $error("double write outputs not mirrored");
   idle_start_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      !a_act |-> PORT_A_WORD_OUT == DPRAM_WORD_ZERO) else $error("port A left idle early");
   clash_flag_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (ra.en && rb.en && !dpram_overlap(a_lo, a_hi, b_lo, b_hi) && !a_wr_bad) |-> !a_rd_bad)
      else $error("port A clash without shared cell");
   settled_read_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      (a_wr && !rb.en && WIDTH_A == WIDTH_B) ##1
      (rb.en && !rb.we && !rb.rst && !b_rd_bad && b_lo == $past(a_lo) && !a_wr)
      |=> PORT_B_WORD_OUT == mask_word($past(ra.din, 2), WIDTH_A))
      else $error("port B missed settled write");
   cov_read: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) ra.en && !ra.we);
   cov_write: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) b_wr);
   cov_ww: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) ww);
   cov_wr: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) a_rd_bad || b_rd_bad);
endmodule

// file: src/dpram_pkg.sv
// Shared constants, carrier types and helpers for the dual-port bit-cell RAM
package dpram_pkg;
   // Array geometry
   localparam int unsigned DPRAM_MEM_BITS = 4096;
   localparam int unsigned DPRAM_ADDR_W = 12;
   localparam int unsigned DPRAM_DATA_W = 16;
   localparam int unsigned DPRAM_SEGS = 16;
   localparam int unsigned DPRAM_SEG_BITS = 256;
   // Age counter of the last-access record
   localparam int unsigned DPRAM_AGE_W = 4;
   localparam logic [DPRAM_AGE_W-1:0] DPRAM_AGE_MAX = 4'hf;
   localparam logic [DPRAM_AGE_W-1:0] DPRAM_AGE_ZERO = 4'h0;
   localparam logic [DPRAM_AGE_W-1:0] DPRAM_AGE_STEP = 4'h1;
   // Reset value of an output word
   localparam logic [DPRAM_DATA_W-1:0] DPRAM_WORD_ZERO = 16'h0000;

   // Start-up contents, one 256-bit segment per index, low segment lowest
   typedef logic [DPRAM_SEGS-1:0][DPRAM_SEG_BITS-1:0] dpram_init_t;
   typedef logic [DPRAM_ADDR_W-1:0] dpram_addr_t;
   typedef logic [DPRAM_DATA_W-1:0] dpram_word_t;

   // One port's inputs as taken at a clock edge
   typedef struct packed {
      logic en;
      logic we;
      logic rst;
      dpram_addr_t addr;
      dpram_word_t din;
   } dpram_req_t;

   // Record of a port's most recent access
   typedef struct packed {
      logic valid;
      logic we;
      dpram_addr_t lo;
      dpram_addr_t hi;
      logic [DPRAM_AGE_W-1:0] age;
   } dpram_last_t;

   // Port activity states
   typedef enum logic [1:0] {
      DPRAM_IDLE = 2'b01,
      DPRAM_ACTIVE = 2'b10
   } dpram_pstate_t;

   // True when two inclusive bit ranges share a cell
   function automatic logic dpram_overlap(input dpram_addr_t lo1, input dpram_addr_t hi1,
                                          input dpram_addr_t lo2, input dpram_addr_t hi2);
      return (lo1 <= hi2) && (lo2 <= hi1);
   endfunction
endpackage

// file: src/dpram_port.sv
// Port front end: polarity options, cell range and last-access record
`timescale 1ns/10ps
module dpram_port
#(
   parameter int unsigned WIDTH = 16,
   parameter bit INV_EN = 1'b0,
   parameter bit INV_WE = 1'b0,
   parameter bit INV_RST = 1'b0
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Raw pins
   input wire logic en_pin,
   input wire logic we_pin,
   input wire logic rst_pin,
   input wire dpram_pkg::dpram_addr_t addr,
   input wire dpram_pkg::dpram_word_t din,
   // Sampled view
   output dpram_pkg::dpram_req_t req,
   output dpram_pkg::dpram_addr_t lo,
   output dpram_pkg::dpram_addr_t hi,
   output dpram_pkg::dpram_last_t last,
   output logic active
);
   import dpram_pkg::*;

   dpram_pstate_t state; // Disabled until first enable
   dpram_pstate_t next_state;
   dpram_last_t next_last;

   // Polarity and range decode
   always_comb
   begin
      req.en = en_pin ^ INV_EN;
      req.we = we_pin ^ INV_WE;
      req.rst = rst_pin ^ INV_RST;
      req.addr = addr;
      req.din = din;
      // word starts at address times width
      lo = DPRAM_ADDR_W'(32'(addr) * WIDTH);
      hi = DPRAM_ADDR_W'(32'(lo) + WIDTH - 1);
   end

   // Next state and last-access record
   always_comb
   begin
      next_state = state;
      next_last = last;
      case (state)
         DPRAM_IDLE:
            if (req.en)
               next_state = DPRAM_ACTIVE;
         DPRAM_ACTIVE:
            next_state = DPRAM_ACTIVE;
         default:
            next_state = DPRAM_IDLE;
      endcase
      if (req.en)
      begin
         next_last.valid = 1'b1;
         next_last.we = req.we;
         next_last.lo = lo;
         next_last.hi = hi;
         next_last.age = DPRAM_AGE_ZERO;
      end
      else if (last.age != DPRAM_AGE_MAX)
         next_last.age = last.age + DPRAM_AGE_STEP;
   end

   // State registers
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= DPRAM_IDLE;
         last <= '0;
      end
      else
      begin
         state <= next_state;
         last <= next_last;
      end
   end

   assign active = (state == DPRAM_ACTIVE);
endmodule

// file: testbench/dpram_user.sv
// Far-side user logic presenting one port's requests
`timescale 1ns/10ps
module dpram_user
(
   // Request towards the RAM port
   output dpram_pkg::dpram_req_t req
);
   import dpram_pkg::*;
   // Quiet port before the first request
   initial req = '0;
   // Launch a request; called just after a rising edge
   task put(input dpram_req_t r);
      // Idle inputs wander, so a disabled port must ignore them
      if (r.en)
         req <= r;
      else
         req <= {1'b0, r.we, r.rst, ~req.addr, ~req.din};
   endtask
endmodule

// file: testbench/dpram_core_tb_top.sv
// Self-checking bench for the dual-port RAM
`timescale 1ns/10ps
module dpram_core_tb_top;
   import dpram_pkg::*;
   // Start-up image: full low segment, short second one, rest zero
   localparam dpram_init_t INIT_V = {{14{256'h0}}, 256'h5a, {4{64'h0123456789abcdef}}};
   localparam logic H = 1'b1;
   localparam logic L = 1'b0;
   localparam dpram_req_t IDLE = '0;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   dpram_req_t ra, rb;
   dpram_word_t out_a, out_b;
   logic act_a, act_b;
   // Outputs of the copy with inverted control pins
   dpram_word_t out_ia, out_ib;
   logic act_ia, act_ib;
   logic [33:0] note;
   // Reference contents and expected outputs
   dpram_word_t m [256];
   dpram_word_t ea, eb;
   logic xa, xb;
   logic [33:0] pend;
   logic pend_v = 1'b0;
   logic [33:0] q [$];
   int mismatches = 0;
   int n_checks = 0;
   integer seed = 32'hba42;
   int i;
   // 100 MHz clock
   always #5 clk_sys = ~clk_sys;
   dpram_user ua (.req(ra));
   dpram_user ub (.req(rb));
   dpram_core #(.INIT(INIT_V)) dut (
      .CLK_SYS(clk_sys), .RESET_N(reset_n),
      .PORT_A_ENABLE(ra.en), .PORT_A_WRITE(ra.we), .PORT_A_OUT_RESET(ra.rst),
      .PORT_A_ADDR(ra.addr), .PORT_A_WORD_IN(ra.din), .PORT_A_WORD_OUT(out_a),
      .PORT_A_ACTIVE(act_a),
      .PORT_B_ENABLE(rb.en), .PORT_B_WRITE(rb.we), .PORT_B_OUT_RESET(rb.rst),
      .PORT_B_ADDR(rb.addr), .PORT_B_WORD_IN(rb.din), .PORT_B_WORD_OUT(out_b),
      .PORT_B_ACTIVE(act_b));
   // Same traffic through inverted enable, write and reset pins
   dpram_core #(.INV_EN_A(1'b1), .INV_WE_A(1'b1), .INV_RST_A(1'b1), .INV_EN_B(1'b1),
      .INV_WE_B(1'b1), .INV_RST_B(1'b1), .INIT(INIT_V)) dut_inv (
      .CLK_SYS(clk_sys), .RESET_N(reset_n),
      .PORT_A_ENABLE(~ra.en), .PORT_A_WRITE(~ra.we), .PORT_A_OUT_RESET(~ra.rst),
      .PORT_A_ADDR(ra.addr), .PORT_A_WORD_IN(ra.din), .PORT_A_WORD_OUT(out_ia),
      .PORT_A_ACTIVE(act_ia),
      .PORT_B_ENABLE(~rb.en), .PORT_B_WRITE(~rb.we), .PORT_B_OUT_RESET(~rb.rst),
      .PORT_B_ADDR(rb.addr), .PORT_B_WORD_IN(rb.din), .PORT_B_WORD_OUT(out_ib),
      .PORT_B_ACTIVE(act_ib));
   function automatic dpram_req_t rq(input logic e, w, r, input dpram_addr_t a,
                                     input dpram_word_t d);
      return {e, w, r, a, d};
   endfunction
   // Random request; base picks the address region
   function automatic dpram_req_t rnd_rq(input logic [7:0] base);
      logic [31:0] r;
      r = $random(seed);
      return rq(r[0] | r[1], r[2], r[3] & r[4] & r[5], {4'h0, base | {5'h0, r[8:6]}},
                r[31:16]);
   endfunction
   // Expected output of port p, other port o on the same edge
   function automatic dpram_word_t pred(input dpram_req_t p, o, input dpram_word_t held);
      if (!p.en)
         return held;
      if (p.rst)
         return 16'h0000;
      if (p.we)
         return p.din;
      if (o.en && o.we && o.addr[7:0] == p.addr[7:0])
         return 16'hxxxx;
      return m[p.addr[7:0]];
   endfunction
   // Contents after configuration or reset
   task model_reset;
      for (i = 0; i < 256; i++)
         m[i] = INIT_V[i >> 4][(i & 15) * 16 +: 16];
      ea = 16'h0000;
      eb = 16'h0000;
      xa = 1'b0;
      xb = 1'b0;
      pend_v = 1'b0;
   endtask
   // One edge of both ports; note queued for the edge that samples it
   task cyc(input dpram_req_t a, b);
      @(posedge clk_sys);
      if (pend_v)
         q.push_back(pend);
      ua.put(a);
      ub.put(b);
      ea = pred(a, b, ea);
      eb = pred(b, a, eb);
      xa = xa | a.en;
      xb = xb | b.en;
      if (a.en && a.we && b.en && b.we && a.addr[7:0] == b.addr[7:0])
         m[a.addr[7:0]] = 16'hxxxx;
      else
      begin
         if (a.en && a.we)
            m[a.addr[7:0]] = a.din;
         if (b.en && b.we)
            m[b.addr[7:0]] = b.din;
      end
      pend = {xa, ea, xb, eb};
      pend_v = 1'b1;
   endtask
   task do_reset;
      @(posedge clk_sys);
      reset_n <= 1'b0;
      model_reset();
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
   endtask
   // Watcher: oldest note against the settled outputs
   always @(negedge clk_sys)
      if (q.size() > 0)
      begin
         note = q.pop_front();
         check(note, {act_a, out_a, act_b, out_b});
         check(note, {act_ia, out_ia, act_ib, out_ib});
      end
   task check(input logic [33:0] exp, got);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      $display("wrong value at %0t: run timed out", $time);
      tally_and_finish();
   end
   initial
   begin
      model_reset();
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      cyc(IDLE, IDLE);
      cyc(rq(H, L, L, 12'h000, 0), rq(H, L, L, 12'h010, 0));
      cyc(rq(H, L, L, 12'h0ff, 0), rq(H, L, L, 12'h01f, 0));
      cyc(rq(H, H, L, 12'h00f, 16'haaaa), IDLE);
      cyc(rq(H, L, L, 12'h00f, 0), rq(H, L, L, 12'h07e, 0));
      cyc(rq(H, H, L, 12'h07e, 16'h9999), IDLE);
      cyc(IDLE, rq(H, L, L, 12'h07e, 0));
      cyc(rq(H, H, L, 12'h00f, 16'h1111), rq(H, H, L, 12'h00f, 16'h2222));
      cyc(rq(H, L, L, 12'h00f, 0), rq(H, L, L, 12'h00f, 0));
      cyc(rq(H, H, L, 12'h030, 16'hc3c3), rq(H, L, L, 12'h030, 0));
      cyc(IDLE, rq(H, L, L, 12'h030, 0));
      cyc(rq(H, H, L, 12'h031, 16'h1234), rq(H, H, L, 12'h032, 16'h4321));
      cyc(rq(H, H, H, 12'h040, 16'hbeef), rq(H, H, L, 12'h041, 16'hcafe));
      cyc(rq(H, L, L, 12'h040, 0), rq(H, L, L, 12'h041, 0));
      // Interleaved 32-bit words: odd half on A, even half on B
      for (int j = 0; j < 4; j++)
         cyc(rq(H, H, L, 12'(2 * j + 1), 16'(j)), rq(H, H, L, 12'(2 * j), 16'(~j)));
      for (int j = 0; j < 4; j++)
         cyc(rq(H, L, L, 12'(2 * j + 1), 0), rq(H, L, L, 12'(2 * j), 0));
      // Random traffic, shared cells first, then split halves
      for (int j = 0; j < 400; j++)
         cyc(rnd_rq(j >= 200 ? 8'h80 : 8'h00), rnd_rq(8'h00));
      cyc(IDLE, IDLE);
      do_reset();
      cyc(IDLE, IDLE);
      cyc(rq(H, L, L, 12'h000, 0), rq(H, L, L, 12'h00f, 0));
      cyc(IDLE, IDLE);
      repeat (3) @(negedge clk_sys);
      if (q.size() != 0)
      begin
         mismatches++;
         $display("wrong value at %0t: notes left unchecked", $time);
      end
      tally_and_finish();
   end
endmodule
